// ==== logic/idio_top.sv ====
// Top: 64-in / 64-out isolated digital I/O with 16 edge interrupts on an Avalon-MM slave
module idio_top #(
  parameter int unsigned N_IN = 64,
  parameter int unsigned N_OUT = 64,
  parameter int unsigned N_IRQ = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [63:0] in_pin_n_i,
  output logic [63:0] out_pin_n_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the register map has room for these sizes only
  if (N_IN != 64) begin : g_bad_in
    $error("idio_top serves exactly 64 inputs");
  end
  if (N_OUT != 64) begin : g_bad_out
    $error("idio_top serves exactly 64 outputs");
  end
  if (N_IRQ != 16) begin : g_bad_irq
    $error("idio_top serves exactly 16 interrupt inputs");
  end
  if (N_IRQ % idio_pkg::GROUP != 0) begin : g_bad_grp
    $error("interrupt inputs must fill whole groups of four");
  end
  if (idio_pkg::TICK_CYC < 2 || idio_pkg::TICK_CYC > 256) begin : g_bad_tick
    $error("filter prescaler period does not fit its 8-bit counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus request bundle
  idio_pkg::idio_avl_req_s req;
  assign req = '{
    address: avs_address_i,
    read: avs_read_i,
    write: avs_write_i,
    writedata: avs_writedata_i,
    byteenable: avs_byteenable_i
  };

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser, two flops per pin
  // Reset to the idle (high) pin level, so no edge is seen when reset ends
  logic [63:0] sync1_q;
  logic [63:0] sync2_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= 64'hFFFF_FFFF_FFFF_FFFF;
      sync2_q <= 64'hFFFF_FFFF_FFFF_FFFF;
    end else begin
      sync1_q <= in_pin_n_i;
      sync2_q <= sync1_q;
    end
  end

  // Invert once here so everything downstream is logical
  logic [63:0] in_log;
  assign in_log = ~sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Filter prescaler
  // One tick per microsecond; filter times are exact to within one tick
  logic [7:0] pre_q;
  logic tick_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (pre_q == 8'(idio_pkg::TICK_CYC - 1)) begin
      pre_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filters, one per input
  // They sit after the synchroniser so they never see a metastable level
  logic [3:0] filt_q;
  logic [63:0] in_filt;

  for (genvar g = 0; g < 64; g++) begin : g_filt
    idio_filter u_filt (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_i(tick_q),
      .sel_i(filt_q),
      .raw_i(in_log[g]),
      .filt_o(in_filt[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect on the interrupt-capable inputs
  logic [15:0] prev_q;
  logic [15:0] edge_sel_q;
  logic [15:0] mask_q;
  logic [15:0] stat_q;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] evt;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 16'h0000;
    end else begin
      prev_q <= in_filt[15:0];
    end
  end

  assign rise = in_filt[15:0] & ~prev_q;
  assign fall = ~in_filt[15:0] & prev_q;
  // Edge bit 1 picks rising, 0 falling
  assign evt = (rise & edge_sel_q) | (fall & ~edge_sel_q);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, answer in the cycle after the request
  // The write commits at the request edge; the master holds it until the answer anyway
  idio_pkg::idio_bus_e bus_q;
  logic hit;
  logic wr_go;
  logic rd_go;

  assign hit = (req.read || req.write) && bus_q == idio_pkg::IDIO_IDLE;
  assign wr_go = hit && req.write;
  assign rd_go = hit && req.read;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_q <= idio_pkg::IDIO_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else begin
      case (bus_q)
        idio_pkg::IDIO_IDLE: begin
          if (hit) begin
            bus_q <= idio_pkg::IDIO_ACK;
            avs_waitrequest_o <= 1'b0;
          end else begin
            avs_waitrequest_o <= 1'b1;
          end
        end
        idio_pkg::IDIO_ACK: begin
          bus_q <= idio_pkg::IDIO_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_q <= idio_pkg::IDIO_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Byte lanes without an enable keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_out_lo;
  logic wr_out_hi;
  logic wr_stat;
  logic wr_mask;
  logic wr_edge;
  logic wr_filt;

  assign wr_out_lo = wr_go && req.address == idio_pkg::OFS_OUT_LO;
  assign wr_out_hi = wr_go && req.address == idio_pkg::OFS_OUT_HI;
  assign wr_stat = wr_go && req.address == idio_pkg::OFS_IRQ_STAT;
  assign wr_mask = wr_go && req.address == idio_pkg::OFS_IRQ_MASK;
  assign wr_edge = wr_go && req.address == idio_pkg::OFS_IRQ_EDGE;
  assign wr_filt = wr_go && req.address == idio_pkg::OFS_FILT;

  ////////////////////////////////////////////////////////////////////////////
  // Output latch, driven inverted to the open-collector stage
  // After reset every pin is high, so no output transistor conducts
  logic [63:0] out_q;
  logic [31:0] out_lo_n;
  logic [31:0] out_hi_n;

  assign out_lo_n = merge(out_q[31:0], req.writedata, req.byteenable);
  assign out_hi_n = merge(out_q[63:32], req.writedata, req.byteenable);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_q <= idio_pkg::OUT_RST;
    end else begin
      if (wr_out_lo) begin
        out_q[31:0] <= out_lo_n;
      end
      if (wr_out_hi) begin
        out_q[63:32] <= out_hi_n;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_pin_n_o <= ~idio_pkg::OUT_RST;
    end else begin
      out_pin_n_o <= ~out_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask, edge and filter configuration
  logic [31:0] mask_n;
  logic [31:0] edge_n;
  logic [31:0] filt_n;

  assign mask_n = merge({16'h0000, mask_q}, req.writedata, req.byteenable);
  assign edge_n = merge({16'h0000, edge_sel_q}, req.writedata, req.byteenable);
  assign filt_n = merge({28'h0000000, filt_q}, req.writedata, req.byteenable);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= idio_pkg::MASK_RST;
      edge_sel_q <= idio_pkg::EDGE_RST;
      filt_q <= idio_pkg::FILT_RST;
    end else begin
      if (wr_mask) begin
        mask_q <= mask_n[15:0];
      end
      if (wr_edge) begin
        edge_sel_q <= edge_n[15:0];
      end
      if (wr_filt) begin
        filt_q <= filt_n[idio_pkg::FILT_LSB +: idio_pkg::FILT_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new edge wins over the clear
  logic [15:0] clr;
  assign clr = wr_stat ? (req.writedata[15:0] & {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}})
                       : 16'h0000;
  // Only enabled bits latch, so unmasking later raises no stale event
  logic [15:0] stat_d;
  assign stat_d = (stat_q & ~clr) | (evt & mask_q);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= 16'h0000;
    end else begin
      stat_q <= stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt merge: four sources per group, groups ORed onto one level
  localparam int unsigned N_GRP = N_IRQ / idio_pkg::GROUP;
  logic [3:0] grp;
  for (genvar k = 0; k < N_GRP; k++) begin : g_grp
    assign grp[k] = |(stat_q[k*idio_pkg::GROUP +: idio_pkg::GROUP] &
                      mask_q[k*idio_pkg::GROUP +: idio_pkg::GROUP]);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |grp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Unmapped offsets read zero; writes to them are answered and dropped
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req.address)
      idio_pkg::OFS_IN_LO: begin
        rd_mux = in_filt[31:0];
      end
      idio_pkg::OFS_IN_HI: begin
        rd_mux = in_filt[63:32];
      end
      idio_pkg::OFS_OUT_LO: begin
        rd_mux = out_q[31:0];
      end
      idio_pkg::OFS_OUT_HI: begin
        rd_mux = out_q[63:32];
      end
      idio_pkg::OFS_IRQ_STAT: begin
        rd_mux = {16'h0000, stat_q};
      end
      idio_pkg::OFS_IRQ_MASK: begin
        rd_mux = {16'h0000, mask_q};
      end
      idio_pkg::OFS_IRQ_EDGE: begin
        rd_mux = {16'h0000, edge_sel_q};
      end
      idio_pkg::OFS_FILT: begin
        rd_mux = {28'h0000000, filt_q};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data stays after the answer, so a late sampler still sees it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata_o <= rd_mux;
    end
  end
endmodule // idio_top

// ==== logic/idio_pkg.sv ====
// Package: register map, field layouts and constants of the isolated digital I/O block
package idio_pkg;
  localparam int unsigned ADDR_W = 5;
  // Register byte offsets inside the 32-byte window
  localparam logic [4:0] OFS_IN_LO = 5'h00;
  localparam logic [4:0] OFS_IN_HI = 5'h04;
  localparam logic [4:0] OFS_OUT_LO = 5'h08;
  localparam logic [4:0] OFS_OUT_HI = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] OFS_IRQ_EDGE = 5'h18;
  localparam logic [4:0] OFS_FILT = 5'h1C;
  // Values after reset
  localparam logic [63:0] OUT_RST = 64'h0000_0000_0000_0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] EDGE_RST = 16'h0000;
  localparam logic [3:0] FILT_RST = 4'h0;
  // Filter field: bits 3:0 pick a stability time of 2^n prescaler ticks, 0 = off
  localparam int unsigned FILT_LSB = 0;
  localparam int unsigned FILT_W = 4;
  // Filter prescaler: one tick per microsecond at 125 MHz
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GROUP = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } idio_avl_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } idio_avl_rsp_s;

  typedef enum logic [1:0] {
    IDIO_IDLE = 2'b00,
    IDIO_ACK = 2'b01
  } idio_bus_e;
endpackage

// ==== logic/idio_filter.sv ====
// Leaf: per-channel chatter filter, passes a level once stable for the selected time
module idio_filter (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic [3:0] sel_i,
  input wire logic raw_i,
  output logic filt_o
);
  logic [15:0] cnt_q;
  logic [15:0] limit;

  assign limit = 16'(16'h0001 << sel_i);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 16'h0000;
      filt_o <= 1'b0;
    end else if (sel_i == 4'h0) begin
      cnt_q <= 16'h0000;
      filt_o <= raw_i;
    end else if (raw_i == filt_o) begin
      cnt_q <= 16'h0000;
    end else if (tick_i) begin
      // Any bounce back to the old level restarts the count above
      if (cnt_q + 16'h0001 >= limit) begin
        cnt_q <= 16'h0000;
        filt_o <= raw_i;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // idio_filter

// ==== test/idio_field.sv ====
// Field wiring model: drives the input pins and reads the output pins
module idio_field (
  input wire logic [63:0] in_log_i,
  output logic [63:0] in_pin_n_o,
  input wire logic [63:0] out_pin_n_i,
  output logic [63:0] out_log_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A closed sinking contact pulls the pin low and reads as one
  assign in_pin_n_o = ~in_log_i;
  assign out_log_o = ~out_pin_n_i;
endmodule // idio_field

// ==== test/idio_top_sva.sv ====
// Checker: bus handshake, pin polarity and interrupt properties of idio_top
module idio_top_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [63:0] in_pin_n_i,
  input wire logic [63:0] out_pin_n_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  logic wr_ack;
  logic rd_ack;
  logic wr_out_lo;
  logic mask_off;
  assign req = avs_read_i | avs_write_i;
  assign wr_ack = avs_write_i & ~avs_waitrequest_o;
  assign rd_ack = avs_read_i & ~avs_waitrequest_o;
  assign wr_out_lo = wr_ack && avs_address_i == idio_pkg::OFS_OUT_LO && avs_byteenable_i == 4'hF;
  assign mask_off = wr_ack && avs_address_i == idio_pkg::OFS_IRQ_MASK
    && avs_writedata_i[15:0] == 16'h0000 && avs_byteenable_i[1:0] == 2'b11;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_ack_next: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait");
  chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_no_spur: assert property (!req |=> avs_waitrequest_o)
    else $error("answer without a request");
  chk_out_pol: assert property (wr_out_lo |=> out_pin_n_o[31:0] == ~$past(avs_writedata_i))
    else $error("output pins not the inverse of written word");
  chk_out_cause: assert property (!$stable(out_pin_n_o) |-> $past(wr_ack))
    else $error("output pins moved without a write");
  chk_rsvd_zero: assert property (rd_ack && avs_address_i[4] |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper interrupt bits not zero");
  chk_mask_quiet: assert property (mask_off |-> ##[1:2] !irq_o)
    else $error("interrupt stays up with all sources masked");
  chk_irq_reset: assert property ($rose(rstn_i) |-> !irq_o)
    else $error("interrupt high right after reset");
endmodule // idio_top_sva

bind idio_top idio_top_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .in_pin_n_i(in_pin_n_i), .out_pin_n_o(out_pin_n_o),
  .irq_o(irq_o));

// ==== test/tb_top.sv ====
// Testbench: register, pin, interrupt and filter scenarios for idio_top
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [4:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rnd, v;
  logic [63:0] in_log, in_pin_n_i, out_pin_n_o, out_log;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;

  idio_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .in_pin_n_i(in_pin_n_i),
    .out_pin_n_o(out_pin_n_o), .irq_o(irq_o));
  idio_field u_field (.in_log_i(in_log), .in_pin_n_o(in_pin_n_i), .out_pin_n_i(out_pin_n_o),
    .out_log_o(out_log));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is seen low; no latency assumed
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) begin
      n_errors++;
      conclude();
    end else begin
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0)
      chk({32'h0, avs_readdata_o}, {32'h0, exp_q.pop_front()});
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    in_log = 64'h0;
    rnd = 32'h8334;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int a = 8; a < 32; a += 4) rd(5'(a), 32'h0000_0000);
    chk(out_pin_n_o, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      v = lfsr(rnd);
      bus(1'b1, idio_pkg::OFS_OUT_LO, rnd);
      bus(1'b1, idio_pkg::OFS_OUT_HI, v);
      rd(idio_pkg::OFS_OUT_LO, rnd);
      chk(out_log, {v, rnd});
      rnd = v;
    end
    bus(1'b1, idio_pkg::OFS_IN_LO, 32'hFFFF_FFFF);
    rd(idio_pkg::OFS_IN_LO, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      v = lfsr(rnd);
      in_log <= {v, rnd};
      repeat (8) @(posedge clk_i);
      rd(idio_pkg::OFS_IN_LO, rnd);
      rd(idio_pkg::OFS_IN_HI, v);
      rnd = v;
    end
    $display("test data paths done");
    in_log <= 64'h0;
    repeat (8) @(posedge clk_i);
    bus(1'b1, idio_pkg::OFS_IRQ_MASK, 32'h0000_FFFF);
    bus(1'b1, idio_pkg::OFS_IRQ_EDGE, 32'h0000_FFFF);
    bus(1'b1, idio_pkg::OFS_IRQ_STAT, 32'h0000_FFFF);
    chk({63'h0, irq_o}, 64'h0);
    in_log <= 64'hFFFF_FFFF_FFFF_A5A5;
    repeat (8) @(posedge clk_i);
    rd(idio_pkg::OFS_IRQ_STAT, 32'h0000_A5A5);
    chk({63'h0, irq_o}, 64'h1);
    bus(1'b1, idio_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk({63'h0, irq_o}, 64'h0);
    bus(1'b1, idio_pkg::OFS_IRQ_EDGE, 32'h0000_0000);
    bus(1'b1, idio_pkg::OFS_IRQ_MASK, 32'h0000_FFFF);
    repeat (3) @(posedge clk_i);
    chk({63'h0, irq_o}, 64'h1);
    bus(1'b1, idio_pkg::OFS_IRQ_STAT, 32'h0000_FFFF);
    repeat (3) @(posedge clk_i);
    chk({63'h0, irq_o}, 64'h0);
    in_log <= 64'hFFFF_FFFF_FFFF_0000;
    repeat (8) @(posedge clk_i);
    rd(idio_pkg::OFS_IRQ_STAT, 32'h0000_A5A5);
    bus(1'b1, idio_pkg::OFS_IRQ_STAT, 32'h0000_FFFF);
    bus(1'b1, idio_pkg::OFS_IRQ_MASK, 32'h0000_00FF);
    bus(1'b1, idio_pkg::OFS_IRQ_EDGE, 32'h0000_FFFF);
    in_log <= 64'hFFFF_FFFF_FFFF_FFFF;
    repeat (8) @(posedge clk_i);
    rd(idio_pkg::OFS_IRQ_STAT, 32'h0000_00FF);
    $display("test interrupts done");
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk({63'h0, irq_o}, 64'h0);
    chk(out_pin_n_o, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(idio_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rd(idio_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    $display("test mid-run reset done");
    bus(1'b1, idio_pkg::OFS_FILT, 32'h0000_0001);
    rd(idio_pkg::OFS_FILT, 32'h0000_0001);
    in_log <= 64'h0;
    repeat (30) @(posedge clk_i);
    rd(idio_pkg::OFS_IN_LO, 32'hFFFF_FFFF);
    repeat (400) @(posedge clk_i);
    rd(idio_pkg::OFS_IN_LO, 32'h0000_0000);
    $display("test filter done");
    bus(1'b1, idio_pkg::OFS_OUT_LO, 32'hFFFF_FFFF);
    avs_byteenable_i <= 4'h5;
    bus(1'b1, idio_pkg::OFS_OUT_LO, 32'h1234_5678);
    avs_byteenable_i <= 4'hF;
    rd(idio_pkg::OFS_OUT_LO, 32'hFF34_FF78);
    chk(out_log, 64'h0000_0000_FF34_FF78);
    $display("test byte lanes done");
    conclude();
  end
endmodule // tb_top
